//--- qdac_consts.vh
// Constants for the quad converter serial input port
`ifndef QDAC_CONSTS_VH
`define QDAC_CONSTS_VH

// Word lengths per variant
`define QDAC_WORD_W_HI       16
`define QDAC_WORD_W_LO       14
// Code widths per variant
`define QDAC_CODE_W_HI       12
`define QDAC_CODE_W_LO       10
// Frame bit counter
`define QDAC_COUNT_RST       5'h00
`define QDAC_COUNT_STEP      5'h01
`define QDAC_COUNT_MAX       5'h1f
// Field positions inside the 16-bit word
`define QDAC_BIT_SHDN_ALL    15
`define QDAC_BIT_SHDN_ONE    14
`define QDAC_BIT_SEL_HI      13
`define QDAC_BIT_SEL_LO      12
`define QDAC_DATA_MSB        11
// Reset values and channel count
`define QDAC_SHIFT_RST       16'h0000
`define QDAC_CODE_RST        12'h000
`define QDAC_SHDN_RST        4'h0
`define QDAC_CHANNELS        4

`endif

//--- qdac_channel.v
// One converter channel: input register, output register and shutdown flag
`timescale 1ns/100ps
`default_nettype none
`include "qdac_consts.vh"

module qdac_channel
#(
	parameter CODE_W = 12
)
(
	input  wire              clk_i,
	input  wire              rst_i,
	input  wire              async_clear_n_i,
	input  wire              write_i,
	input  wire              load_i,
	input  wire [CODE_W-1:0] code_i,
	input  wire              shdn_set_i,
	input  wire              shdn_write_i,
	output reg  [CODE_W-1:0] code_o,
	output reg               shdn_o
);

reg [CODE_W-1:0] input_reg_ff;

//==========================================================
// Double buffered registers
always @(posedge clk_i or posedge rst_i)
begin
	if (rst_i)
	begin
		input_reg_ff <= {CODE_W{1'b0}};
		code_o       <= {CODE_W{1'b0}};
		shdn_o       <= 1'b0;
	end
	else if (!async_clear_n_i)
	begin
		input_reg_ff <= {CODE_W{1'b0}};
		code_o       <= {CODE_W{1'b0}};
		shdn_o       <= 1'b0;
	end
	else
	begin
		if (write_i)
			input_reg_ff <= code_i;
		if (shdn_write_i)
			shdn_o <= shdn_set_i;
		// A write and a load in the same cycle pass the new code straight on
		if (load_i)
			code_o <= write_i ? code_i : input_reg_ff;
	end
end

endmodule // qdac_channel

`default_nettype wire

//--- qdac_serial_port.v
// Serial input port of a quad voltage-output converter
// Operation
// - Serial data is sampled into the shift register on each rising serial clock edge while chip select is low.
// - Words are shifted most significant bit first, 16 bits wide or 14 bits for the 10-bit variant.
// - The 10-bit variant keeps only the last 14 bits shifted in and drops any earlier ones.
// - When chip select rises after a transfer the new word is loaded into the addressed channel.
// - Clock edges enter the shift register only while chip select is low.
// - The target channel is chosen by decoding the two channel-select bits of the word.
// - Shutdown-all set shuts all channels, else shutdown-one set shuts the addressed channel.
// - Outputs update either automatically after a word or under control of the load strobe.
`timescale 1ns/100ps
`default_nettype none
`include "qdac_consts.vh"

module qdac_serial_port
#(
	parameter TEN_BIT = 0
)
(
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        serial_clk_i,
	input  wire        serial_in_line_i,
	input  wire        chip_select_n_i,
	input  wire        output_load_strobe_n_i,
	input  wire        async_clear_n_i,
	input  wire        auto_update_i,
	output wire [11:0] code_a_o,
	output wire [11:0] code_b_o,
	output wire [11:0] code_c_o,
	output wire [11:0] code_d_o,
	output wire [3:0]  shutdown_o,
	output reg         word_done_o,
	output reg  [4:0]  bit_count_o
);

localparam CODE_W = TEN_BIT ? `QDAC_CODE_W_LO : `QDAC_CODE_W_HI;

reg  [15:0] shift_ff;
reg  [15:0] nxt_shift;
reg         sclk_ff;
reg         cs_n_ff;
reg         load_pend_ff;
reg  [4:0]  nxt_count;
wire        sclk_rise;
wire        cs_rise;
wire [15:0] word;
wire [1:0]  sel;
wire        shdn_all;
wire        shdn_one;
wire        load_now;
wire [CODE_W-1:0] new_code;
wire [3:0]  chan_write;
wire [3:0]  shdn_write;
wire        shdn_val;

//==========================================================
// Edge detection on the host's clock and select
assign sclk_rise = serial_clk_i & ~sclk_ff;
assign cs_rise   = chip_select_n_i & ~cs_n_ff;

always @*
begin
	nxt_shift = shift_ff;
	nxt_count = bit_count_o;
	if (!chip_select_n_i && sclk_rise)
	begin
		nxt_shift = {shift_ff[`QDAC_WORD_W_HI-2:0], serial_in_line_i};
		if (bit_count_o != `QDAC_COUNT_MAX)
			nxt_count = bit_count_o + `QDAC_COUNT_STEP;
	end
	if (cs_rise)
		nxt_count = `QDAC_COUNT_RST;
end

//==========================================================
// Samples of the host's clock and select from the last edge
always @(posedge clk_i or posedge rst_i)
begin
	if (rst_i)
	begin
		sclk_ff <= 1'b0;
		cs_n_ff <= 1'b1;
	end
	else
	begin
		sclk_ff <= serial_clk_i;
		cs_n_ff <= chip_select_n_i;
	end
end

//==========================================================
// Input shift register and frame bit counter
always @(posedge clk_i or posedge rst_i)
begin
	if (rst_i)
	begin
		shift_ff    <= `QDAC_SHIFT_RST;
		bit_count_o <= `QDAC_COUNT_RST;
	end
	else
	begin
		shift_ff    <= async_clear_n_i ? nxt_shift : `QDAC_SHIFT_RST;
		bit_count_o <= nxt_count;
	end
end

//==========================================================
// End-of-word pulse and pending automatic update
always @(posedge clk_i or posedge rst_i)
begin
	if (rst_i)
	begin
		word_done_o  <= 1'b0;
		load_pend_ff <= 1'b0;
	end
	else
	begin
		word_done_o <= cs_rise;
		// A new word wins over the load's clear of the pending update, but the async clear wins over both
		if (!async_clear_n_i)
			load_pend_ff <= 1'b0;
		else if (cs_rise && auto_update_i)
			load_pend_ff <= 1'b1;
		else if (load_now)
			load_pend_ff <= 1'b0;
	end
end

//==========================================================
// Word decode: the 10-bit variant sees the last 14 bits as its word
assign word     = TEN_BIT ?
	{shift_ff[`QDAC_WORD_W_LO-1:0], {(`QDAC_WORD_W_HI-`QDAC_WORD_W_LO){1'b0}}} : shift_ff;
assign shdn_all = word[`QDAC_BIT_SHDN_ALL];
assign shdn_one = word[`QDAC_BIT_SHDN_ONE];
assign sel      = {word[`QDAC_BIT_SEL_HI], word[`QDAC_BIT_SEL_LO]};
assign new_code = word[`QDAC_DATA_MSB -: CODE_W];

// Auto update one cycle after the word lands, or level-sensitive load strobe
assign load_now = load_pend_ff | ~output_load_strobe_n_i;

//==========================================================
// Channel decode and the four channel registers
assign shdn_val      = shdn_all | shdn_one;
assign chan_write[0] = cs_rise && (sel == 2'h0);
assign chan_write[1] = cs_rise && (sel == 2'h1);
assign chan_write[2] = cs_rise && (sel == 2'h2);
assign chan_write[3] = cs_rise && (sel == 2'h3);
// Shutdown-all writes every flag, otherwise only the addressed one
assign shdn_write    = chan_write | {`QDAC_CHANNELS{cs_rise & shdn_all}};

qdac_channel
#(
	.CODE_W          (CODE_W)
)
u_chan_a
(
	.clk_i           (clk_i),
	.rst_i           (rst_i),
	.async_clear_n_i (async_clear_n_i),
	.write_i         (chan_write[0]),
	.load_i          (load_now),
	.code_i          (new_code),
	.shdn_set_i      (shdn_val),
	.shdn_write_i    (shdn_write[0]),
	.code_o          (code_a_o[CODE_W-1:0]),
	.shdn_o          (shutdown_o[0])
);

qdac_channel
#(
	.CODE_W          (CODE_W)
)
u_chan_b
(
	.clk_i           (clk_i),
	.rst_i           (rst_i),
	.async_clear_n_i (async_clear_n_i),
	.write_i         (chan_write[1]),
	.load_i          (load_now),
	.code_i          (new_code),
	.shdn_set_i      (shdn_val),
	.shdn_write_i    (shdn_write[1]),
	.code_o          (code_b_o[CODE_W-1:0]),
	.shdn_o          (shutdown_o[1])
);

qdac_channel
#(
	.CODE_W          (CODE_W)
)
u_chan_c
(
	.clk_i           (clk_i),
	.rst_i           (rst_i),
	.async_clear_n_i (async_clear_n_i),
	.write_i         (chan_write[2]),
	.load_i          (load_now),
	.code_i          (new_code),
	.shdn_set_i      (shdn_val),
	.shdn_write_i    (shdn_write[2]),
	.code_o          (code_c_o[CODE_W-1:0]),
	.shdn_o          (shutdown_o[2])
);

qdac_channel
#(
	.CODE_W          (CODE_W)
)
u_chan_d
(
	.clk_i           (clk_i),
	.rst_i           (rst_i),
	.async_clear_n_i (async_clear_n_i),
	.write_i         (chan_write[3]),
	.load_i          (load_now),
	.code_i          (new_code),
	.shdn_set_i      (shdn_val),
	.shdn_write_i    (shdn_write[3]),
	.code_o          (code_d_o[CODE_W-1:0]),
	.shdn_o          (shutdown_o[3])
);

//==========================================================
// The 10-bit variant leaves the top code bits at zero
generate
	if (CODE_W < `QDAC_CODE_W_HI)
	begin : g_pad
		assign code_a_o[`QDAC_CODE_W_HI-1:CODE_W] = {(`QDAC_CODE_W_HI-CODE_W){1'b0}};
		assign code_b_o[`QDAC_CODE_W_HI-1:CODE_W] = {(`QDAC_CODE_W_HI-CODE_W){1'b0}};
		assign code_c_o[`QDAC_CODE_W_HI-1:CODE_W] = {(`QDAC_CODE_W_HI-CODE_W){1'b0}};
		assign code_d_o[`QDAC_CODE_W_HI-1:CODE_W] = {(`QDAC_CODE_W_HI-CODE_W){1'b0}};
	end
endgenerate

endmodule // qdac_serial_port

`default_nettype wire

//--- qdac_port_asserts.sv
// Checker on the serial port outputs
`timescale 1ns/100ps
`default_nettype none
module qdac_port_asserts
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        serial_clk_i,
	input wire logic        chip_select_n_i,
	input wire logic        output_load_strobe_n_i,
	input wire logic        async_clear_n_i,
	input wire logic        word_done_o,
	input wire logic [11:0] code_a_o,
	input wire logic [11:0] code_b_o,
	input wire logic [11:0] code_c_o,
	input wire logic [11:0] code_d_o,
	input wire logic [3:0]  shutdown_o,
	input wire logic [4:0]  bit_count_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire [47:0] codes = {code_a_o, code_b_o, code_c_o, code_d_o};
	sequence take_s; $rose(serial_clk_i) && !chip_select_n_i; endsequence
	sequence rise_s; $rose(chip_select_n_i); endsequence
	done_pulse_a: assert property (rise_s |-> ##[1:2] word_done_o)
		else $error("late done");
	done_once_a: assert property (word_done_o |=> !word_done_o)
		else $error("long done");
	done_cause_a: assert property (word_done_o |-> $past(chip_select_n_i) &&
		!($past(chip_select_n_i, 2) && $past(chip_select_n_i, 3))) else $error("stray done");
	count_step_a: assert property (take_s ##0 bit_count_o != 5'h1f |=>
		bit_count_o == $past(bit_count_o) + 5'h01) else $error("bad count");
	idle_count_a: assert property (chip_select_n_i [*3] |-> bit_count_o == 5'h00)
		else $error("idle count");
	codes_hold_a: assert property (output_load_strobe_n_i && async_clear_n_i &&
		!word_done_o && chip_select_n_i == $past(chip_select_n_i, 2) |=> $stable(codes))
		else $error("code moved");
	shdn_hold_a: assert property (!$rose(chip_select_n_i) && async_clear_n_i |=>
		$stable(shutdown_o)) else $error("shutdown moved");
	clear_zero_a: assert property (!async_clear_n_i |=> !codes && !shutdown_o && !bit_count_o)
		else $error("no clear");
endmodule // qdac_port_asserts
bind qdac_serial_port qdac_port_asserts chk_u(.*);
`default_nettype wire

//--- qdac_host_model.sv
// Host serial master driving the port
`timescale 1ns/100ps
`default_nettype none
module qdac_host_model(
	input  wire logic clk_i,
	output var  logic sclk_o = 1'b0,
	output var  logic sdi_o  = 1'b1,
	output var  logic cs_n_o = 1'b1,
	output var  logic ld_n_o = 1'b1
);
	task automatic shift(input [23:0] w, input [4:0] n);
		cs_n_o <= 1'b0;
		for (int i = n - 1; i >= 0; i--)
		begin
			repeat (2) @(posedge clk_i);
			sclk_o <= 1'b0;
			sdi_o <= w[i];
			repeat (2) @(posedge clk_i);
			sclk_o <= 1'b1;
		end
		repeat (2) @(posedge clk_i);
		sclk_o <= 1'b0;
		repeat (2) @(posedge clk_i);
		cs_n_o <= 1'b1;
		sdi_o <= ~sdi_o;
		repeat (4) @(posedge clk_i);
	endtask
	// Load pulse with a stray clock while deselected
	task strobe;
		ld_n_o <= 1'b0;
		sclk_o <= 1'b1;
		repeat (2) @(posedge clk_i);
		ld_n_o <= 1'b1;
		sclk_o <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
endmodule // qdac_host_model
`default_nettype wire

//--- test_qdac_serial_port.sv
// Random and corner frames into the serial port
`timescale 1ns/100ps
`default_nettype none
module test_qdac_serial_port;
	logic        clk_i = 1'b0, rst_i = 1'b1, async_clear_n_i = 1'b1, auto_update_i = 1'b1;
	wire         serial_clk_i, serial_in_line_i, chip_select_n_i, output_load_strobe_n_i;
	wire  [11:0] code_a_o, code_b_o, code_c_o, code_d_o;
	wire  [3:0]  shutdown_o;
	wire         word_done_o;
	wire  [4:0]  bit_count_o;
	wire  [11:0] c10_a, c10_b, c10_c, c10_d;
	wire  [3:0]  sd10;
	wire         done10;
	wire  [4:0]  cnt10;
	logic [11:0] e_in[4], e_out[4], e_in10[4], e_out10[4];
	logic [3:0]  e_sd, e_sd10;
	logic [23:0] w;
	logic [9:0]  cnt_seen = 10'h000;
	int          n_mismatch = 0, total_checks = 0, seed = 32'h4727dc34;
	int          n_done = 0, frames = 0;
	always #4 clk_i = ~clk_i;
	qdac_host_model host_u(.clk_i, .sclk_o(serial_clk_i), .sdi_o(serial_in_line_i),
		.cs_n_o(chip_select_n_i), .ld_n_o(output_load_strobe_n_i));
	qdac_serial_port dut_u(.*);
	qdac_serial_port #(.TEN_BIT(1)) dut10_u(.clk_i, .rst_i, .serial_clk_i, .serial_in_line_i,
		.chip_select_n_i, .output_load_strobe_n_i, .async_clear_n_i, .auto_update_i,
		.code_a_o(c10_a), .code_b_o(c10_b), .code_c_o(c10_c), .code_d_o(c10_d),
		.shutdown_o(sd10), .word_done_o(done10), .bit_count_o(cnt10));
	// Count end-of-word pulses and keep the bit counts seen while selected
	always @(posedge clk_i)
	begin
		n_done += (word_done_o === 1'b1) + (done10 === 1'b1);
		if (!chip_select_n_i)
			cnt_seen <= {cnt10, bit_count_o};
	end
	task chk(input [47:0] s, e);
		total_checks++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("MISMATCH %0t got %h want %h", $time, s, e);
		end
	endtask
	task test_done;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task cmp;
		#1;
		chk({code_a_o, code_b_o, code_c_o, code_d_o}, {e_out[0], e_out[1], e_out[2], e_out[3]});
		chk({c10_a, c10_b, c10_c, c10_d}, {e_out10[0], e_out10[1], e_out10[2], e_out10[3]});
		chk({sd10, shutdown_o}, {e_sd10, e_sd});
		chk({done10, cnt10, word_done_o, bit_count_o}, 12'h000);
		chk(n_done, frames * 2);
		@(posedge clk_i);
	endtask
	function automatic [3:0] next_sd(input [3:0] o, input [15:0] v);
		next_sd = o;
		next_sd[v[13:12]] = v[14];
		if (v[15]) next_sd = 4'hf;
	endfunction
	task frame(input [4:0] n);
		host_u.shift(w, n);
		frames++;
		e_in[w[13:12]] = w[11:0];
		e_sd = next_sd(e_sd, w[15:0]);
		e_in10[w[11:10]] = {2'h0, w[9:0]};
		e_sd10 = next_sd(e_sd10, {w[13:0], 2'h0});
		if (auto_update_i)
		begin
			e_out = e_in;
			e_out10 = e_in10;
		end
		chk(cnt_seen, {n, n});
		cmp();
	endtask
	initial
	begin
		e_in = '{default:12'h0};
		e_out = e_in;
		e_in10 = e_in;
		e_out10 = e_in;
		e_sd = 4'h0;
		e_sd10 = 4'h0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		cmp();
		for (int i = 0; i < 15; i++)
		begin
			w = 24'($random(seed));
			if (i < 4) w[15:12] = {2'h1, i[1:0]};
			if (i == 14) auto_update_i <= 1'b0;
			frame(i[0] ? 5'h18 : 5'h10);
		end
		host_u.strobe();
		e_out = e_in;
		e_out10 = e_in10;
		cmp();
		async_clear_n_i <= 1'b0;
		@(posedge clk_i);
		async_clear_n_i <= 1'b1;
		auto_update_i <= 1'b1;
		e_in = '{default:12'h0};
		e_out = e_in;
		e_in10 = e_in;
		e_out10 = e_in;
		e_sd = 4'h0;
		e_sd10 = 4'h0;
		cmp();
		// A stray clock while deselected must not reach the next word
		w = 24'($random(seed));
		frame(5'h10);
		test_done();
	end
	initial
	begin
		#200000;
		n_mismatch++;
		test_done();
	end
endmodule // test_qdac_serial_port
`default_nettype wire
